// ==== hw/su_regs.svh ====
`ifndef SU_REGS_SVH
`define SU_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SU_CTRL_HIGH_OFF  8'h_F9
`define SU_CTRL_LOW_OFF   8'h_FA
`define SU_BUFFER_OFF     8'h_FB
`define SU_DIVISOR_OFF    8'h_FC
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SU_H_MODE_HI      7
`define SU_H_MODE_LO      6
`define SU_H_MCE          5
`define SU_H_RE           4
`define SU_H_TB8          3
`define SU_H_RB8          2
`define SU_H_RIE          1
`define SU_H_RIP          0
`define SU_L_PAR          7
`define SU_L_CSEL_HI      3
`define SU_L_CSEL_LO      2
`define SU_L_TIE          1
`define SU_L_TIP          0
// ----------------------------------------
// Modes, reset values and timing
// ----------------------------------------
`define SU_MODE_SHIFT     2'h0
`define SU_MODE_ASYNC8    2'h1
`define SU_MODE_FIXED9    2'h2
`define SU_MODE_VAR9      2'h3
`define SU_REG_RESET      8'h_00
`define SU_TICK_LAST      4'h_F
`define SU_TICK_CENTRE    4'h_7
`define SU_BIT_LAST       3'h7
`define SU_TICK_ZERO      4'h_0
`define SU_BIT_ZERO       3'h0
`endif

// ==== hw/su_pkg.sv ====
package su_pkg;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} su_tx_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP,
                             RX_SYNC} su_rx_e;
   typedef logic [7:0] su_byte_t;
endpackage : su_pkg

// ==== hw/su_baud.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "su_regs.svh"
module su_baud
   import su_pkg::*;
(
   input  wire logic  mclk,
   input  wire logic  reset_n,
   input  wire logic  [7:0] divisor,
   input  wire logic  fixed_rate,
   output var  logic  tick
);
   logic [7:0] cnt_ff;
   logic [7:0] reload;

   // Sixteen ticks per bit: divisor+1 clocks per tick, one clock in fixed mode
   assign reload = fixed_rate ? `SU_REG_RESET : divisor;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= `SU_REG_RESET;
         tick   <= 1'b0;
      end else if (cnt_ff == `SU_REG_RESET) begin
         cnt_ff <= reload;
         tick   <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff - 8'h_01;
         tick   <= 1'b0;
      end
   end

   // R10 tick reload count
   baud_reload_a: assert property (@(posedge mclk) disable iff (!reset_n) // R10
      tick |-> cnt_ff == $past(reload)) else $error("Baud reload mismatch");
endmodule : su_baud
`default_nettype wire

// ==== hw/su_fifo2.sv ====
`timescale 1ns/1ps
`default_nettype none
module su_fifo2
   import su_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             out_valid,
   input  wire logic             out_ready,
   output var  logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_ff;
   logic [AW-1:0]    rp_ff;
   logic [AW:0]      cnt_ff;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem[rp_ff];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction : inc

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wp_ff] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) wp_ff <= inc(wp_ff);
         if (pop) rp_ff <= inc(rp_ff);
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : su_fifo2
`default_nettype wire

// ==== hw/su_uart.sv ====
// Behaviour
// R1: Mode 0 receive flag after eighth bit
// R2: Mode 1 receive flag at stop centre
// R3: Modes 2/3 receive flag at ninth-bit centre
// R4: Software clears the receive flag
// R5: Mode 0 transmit flag after eighth bit
// R6: Async transmit flag at stop start
// R7: Software clears the transmit flag
// R8: Mode 0 rate uses divisor
// R9: Mode 2 rate fixed divide sixteen
// R10: Modes 1/3 rate uses divisor
// R11: Mode 0 data on input pin
// R12: Mode 0 receive starts flag clear, enabled
// R13: Receive interrupt gated by its enable
// R14: Mode field in high bits 7:6
// R15: Buffer write starts a transmission
// R16: Mode 1 frame start, eight, stop
// R17: Start and stop inserted automatically
// R18: Low start bit begins async receive
// R19: Clock source field low bits 3:2
// R20: Low bit 7 enables parity generation
// R21: Modes 2/3 are nine-bit frames
// R22: Writing zero clears receive flag
// R23: Mode 1 filter needs valid stop
// R24: Unread byte overrun loses one byte
// R25: Sixteen ticks, centre sampling
// R26: Reads see receive holding buffer
`timescale 1ns/1ps
`default_nettype none
`include "su_regs.svh"
module su_uart
   import su_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output var  logic [7:0] reg_rdata,
   output var  logic       rx_irq,
   output var  logic       tx_irq,
   output var  logic [1:0] uart_clk_sel,
   output var  logic       serial_out_pin,
   input  wire logic       serial_in_pin_i,
   output var  logic       serial_in_pin_o,
   output var  logic       serial_in_pin_oe
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [1:0] mode_ff;
   logic       mce_ff, re_ff, tb8_ff, rb8_ff, rie_ff, rip_ff;
   logic       par_ff, tie_ff, tip_ff;
   logic [7:0] div_ff;
   su_tx_e     tx_state_ff;
   su_rx_e     rx_state_ff;
   logic [7:0] tx_sh_ff, rx_sh_ff;
   logic [2:0] tx_bit_ff, rx_bit_ff;
   logic [3:0] tx_tick_ff, rx_tick_ff;
   logic       tx_ninth_ff;
   logic       tick, mode0, nine;
   logic       wr_high, wr_low, wr_buf, rd_buf;
   logic       tx_end_bit, rx_end_bit, rx_centre;
   logic       rx_set, tx_set, rx_push, fifo_ready, fifo_valid;
   logic [7:0] fifo_data;
   logic       nxt_txd, nxt_pin_o, nxt_pin_oe;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : hit

   assign wr_high = reg_wr && hit(reg_addr, `SU_CTRL_HIGH_OFF);
   assign wr_low  = reg_wr && hit(reg_addr, `SU_CTRL_LOW_OFF);
   assign wr_buf  = reg_wr && hit(reg_addr, `SU_BUFFER_OFF);
   assign rd_buf  = reg_rd && hit(reg_addr, `SU_BUFFER_OFF);
   // R14 mode field
   assign mode0   = (mode_ff == `SU_MODE_SHIFT);
   // R21 nine-bit modes
   assign nine    = mode_ff[1];

   // ----------------------------------------
   // Baud tick and receive buffer
   // ----------------------------------------
   // R9 fixed rate in mode 2
   su_baud u_baud (
      .mclk       (mclk),
      .reset_n    (reset_n),
      .divisor    (div_ff),
      .fixed_rate (mode_ff == `SU_MODE_FIXED9),
      .tick       (tick)
   );

   su_fifo2 #(.WIDTH(8), .DEPTH(2)) u_rxbuf (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .in_valid  (rx_push),
      .in_ready  (fifo_ready),
      .in_data   (rx_sh_ff),
      .out_valid (fifo_valid),
      .out_ready (rd_buf),
      .out_data  (fifo_data)
   );

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         {mode_ff, mce_ff, re_ff, tb8_ff, rie_ff} <= 6'h_00;
         {par_ff, uart_clk_sel, tie_ff}          <= 4'h0;
         div_ff                                   <= `SU_REG_RESET;
      end else begin
         if (wr_high) begin
            mode_ff <= reg_wdata[`SU_H_MODE_HI:`SU_H_MODE_LO];
            mce_ff  <= reg_wdata[`SU_H_MCE];
            re_ff   <= reg_wdata[`SU_H_RE];
            tb8_ff  <= reg_wdata[`SU_H_TB8];
            rie_ff  <= reg_wdata[`SU_H_RIE];
         end
         if (wr_low) begin
            // R20 parity enable
            par_ff       <= reg_wdata[`SU_L_PAR];
            // R19 clock source
            uart_clk_sel <= reg_wdata[`SU_L_CSEL_HI:`SU_L_CSEL_LO];
            tie_ff       <= reg_wdata[`SU_L_TIE];
         end
         if (reg_wr && hit(reg_addr, `SU_DIVISOR_OFF)) div_ff <= reg_wdata;
      end
   end

   // R22 write zero clears, hardware set wins
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rip_ff <= 1'b0;
         tip_ff <= 1'b0;
      end else begin
         // R4 only software clears
         if (rx_set) rip_ff <= 1'b1;
         else if (wr_high && !reg_wdata[`SU_H_RIP]) rip_ff <= 1'b0;
         // R7 only software clears
         if (tx_set) tip_ff <= 1'b1;
         else if (wr_low && !reg_wdata[`SU_L_TIP]) tip_ff <= 1'b0;
      end
   end

   // R26 reads return receive buffer
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= `SU_REG_RESET;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `SU_CTRL_HIGH_OFF: reg_rdata <= {mode_ff, mce_ff, re_ff, tb8_ff, rb8_ff,
                                             rie_ff, rip_ff};
            `SU_CTRL_LOW_OFF:  reg_rdata <= {par_ff, 3'h0, uart_clk_sel, tie_ff,
                                             tip_ff};
            `SU_BUFFER_OFF:    reg_rdata <= fifo_valid ? fifo_data : `SU_REG_RESET;
            `SU_DIVISOR_OFF:   reg_rdata <= div_ff;
            default:           reg_rdata <= `SU_REG_RESET;
         endcase
      end
   end

   // R13 receive interrupt gated
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_irq <= 1'b0;
         tx_irq <= 1'b0;
      end else begin
         rx_irq <= rip_ff && rie_ff;
         tx_irq <= tip_ff && tie_ff;
      end
   end

   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   // R8 R10 R25 sixteen ticks per bit
   assign tx_end_bit = tick && (tx_tick_ff == `SU_TICK_LAST);
   // R5 R6 transmit flag points
   assign tx_set = (tx_state_ff == TX_DATA && mode0 && tx_end_bit
                    && tx_bit_ff == `SU_BIT_LAST)
                || (tx_end_bit && !mode0 && ((tx_state_ff == TX_NINTH)
                    || (tx_state_ff == TX_DATA && !nine
                        && tx_bit_ff == `SU_BIT_LAST)));

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_state_ff <= TX_IDLE;
         tx_sh_ff    <= `SU_REG_RESET;
         tx_bit_ff   <= `SU_BIT_ZERO;
         tx_tick_ff  <= `SU_TICK_ZERO;
         tx_ninth_ff <= 1'b0;
      end else begin
         if (tick && tx_state_ff != TX_IDLE) tx_tick_ff <= tx_tick_ff + 4'h1;
         unique case (tx_state_ff)
            TX_IDLE: begin
               // R15 write starts transmission
               if (wr_buf && !(mode0 && rx_state_ff == RX_SYNC)) begin
                  tx_sh_ff    <= reg_wdata;
                  tx_ninth_ff <= par_ff ? ^reg_wdata : tb8_ff;
                  tx_bit_ff   <= `SU_BIT_ZERO;
                  tx_tick_ff  <= `SU_TICK_ZERO;
                  // R17 start bit inserted
                  tx_state_ff <= mode0 ? TX_DATA : TX_START;
               end
            end
            TX_START: if (tx_end_bit) tx_state_ff <= TX_DATA;
            TX_DATA: begin
               if (tx_end_bit) begin
                  tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
                  tx_bit_ff <= tx_bit_ff + 3'h1;
                  if (tx_bit_ff == `SU_BIT_LAST) begin
                     tx_state_ff <= mode0 ? TX_IDLE : (nine ? TX_NINTH : TX_STOP);
                  end
               end
            end
            TX_NINTH: if (tx_end_bit) tx_state_ff <= TX_STOP;
            TX_STOP:  if (tx_end_bit) tx_state_ff <= TX_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   always_comb begin
      nxt_txd    = 1'b1;
      nxt_pin_o  = 1'b1;
      nxt_pin_oe = 1'b0;
      if (mode0) begin
         // R11 shift clock on output pin, data on input pin
         if (tx_state_ff == TX_DATA) begin
            nxt_txd    = tx_tick_ff[3];
            nxt_pin_o  = tx_sh_ff[0];
            nxt_pin_oe = 1'b1;
         end else if (rx_state_ff == RX_SYNC) begin
            nxt_txd = rx_tick_ff[3];
         end
      end else begin
         // R16 frame levels
         unique case (tx_state_ff)
            TX_START: nxt_txd = 1'b0;
            TX_DATA:  nxt_txd = tx_sh_ff[0];
            TX_NINTH: nxt_txd = tx_ninth_ff;
            default:  nxt_txd = 1'b1;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         serial_out_pin   <= 1'b1;
         serial_in_pin_o  <= 1'b1;
         serial_in_pin_oe <= 1'b0;
      end else begin
         serial_out_pin   <= nxt_txd;
         serial_in_pin_o  <= nxt_pin_o;
         serial_in_pin_oe <= nxt_pin_oe;
      end
   end

   // ----------------------------------------
   // Receiver
   // ----------------------------------------
   // R25 sample at bit centre
   assign rx_end_bit = tick && (rx_tick_ff == `SU_TICK_LAST);
   assign rx_centre  = tick && (rx_tick_ff == `SU_TICK_CENTRE);
   // R1 R2 R3 R23 receive flag points
   assign rx_set = (rx_state_ff == RX_SYNC && rx_end_bit && rx_bit_ff == `SU_BIT_LAST)
                || (rx_end_bit && rx_state_ff == RX_STOP && !nine
                    && !(mce_ff && !serial_in_pin_i))
                || (rx_end_bit && rx_state_ff == RX_NINTH
                    && !(mce_ff && !serial_in_pin_i));
   // R24 full buffer drops the new byte
   assign rx_push = rx_set && fifo_ready;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_state_ff <= RX_IDLE;
         rx_sh_ff    <= `SU_REG_RESET;
         rx_bit_ff   <= `SU_BIT_ZERO;
         rx_tick_ff  <= `SU_TICK_ZERO;
         rb8_ff      <= 1'b0;
      end else begin
         if (tick && rx_state_ff != RX_IDLE) rx_tick_ff <= rx_tick_ff + 4'h1;
         unique case (rx_state_ff)
            RX_IDLE: begin
               rx_tick_ff <= `SU_TICK_ZERO;
               rx_bit_ff  <= `SU_BIT_ZERO;
               if (re_ff && mode0) begin
                  // R12 enabled with flag clear
                  if (!rip_ff && tx_state_ff == TX_IDLE && !wr_buf)
                     rx_state_ff <= RX_SYNC;
               end else if (re_ff && !serial_in_pin_i) begin
                  // R18 low start condition
                  rx_state_ff <= RX_START;
               end
            end
            RX_START: begin
               if (rx_centre) begin
                  rx_tick_ff  <= `SU_TICK_ZERO;
                  rx_state_ff <= serial_in_pin_i ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_end_bit) begin
                  rx_sh_ff  <= {serial_in_pin_i, rx_sh_ff[7:1]};
                  rx_bit_ff <= rx_bit_ff + 3'h1;
                  if (rx_bit_ff == `SU_BIT_LAST) rx_state_ff <= nine ? RX_NINTH : RX_STOP;
               end
            end
            RX_NINTH: begin
               if (rx_end_bit) begin
                  rb8_ff      <= serial_in_pin_i;
                  rx_state_ff <= RX_STOP;
               end
            end
            RX_STOP: if (rx_end_bit) rx_state_ff <= RX_IDLE;
            RX_SYNC: begin
               // R11 least significant bit first
               if (rx_centre) rx_sh_ff <= {serial_in_pin_i, rx_sh_ff[7:1]};
               if (rx_end_bit) begin
                  rx_bit_ff <= rx_bit_ff + 3'h1;
                  if (rx_bit_ff == `SU_BIT_LAST) rx_state_ff <= RX_IDLE;
               end
            end
            default: rx_state_ff <= RX_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // R1 R2 R3 flag follows event
   rip_set_a: assert property (rx_set |=> rip_ff) // R1
      else $error("Receive flag not set");
   // R22 flag holds until cleared
   rip_hold_a: assert property (rip_ff && !(wr_high && !reg_wdata[`SU_H_RIP]) // R22
      |=> rip_ff)
      else $error("Receive flag lost");
   // R22 zero write clears
   rip_clear_a: assert property (wr_high && !reg_wdata[`SU_H_RIP] && !rx_set // R22
      |=> !rip_ff)
      else $error("Receive flag not cleared");
   // R6 flag at stop start
   tip_stop_a: assert property (tx_state_ff == TX_STOP && $past(tx_state_ff) != TX_STOP // R6
      |-> tip_ff)
      else $error("Transmit flag late");
   // R15 write starts frame
   tx_start_a: assert property (tx_state_ff == TX_IDLE && wr_buf && !mode0 // R15
      |=> tx_state_ff == TX_START)
      else $error("Transmission not started");
   // R16 frame levels on line
   frame_level_a: assert property ((!mode0 && tx_state_ff == TX_START |=> !serial_out_pin) // R16
      and (!mode0 && tx_state_ff == TX_STOP |=> serial_out_pin))
      else $error("Frame level wrong");
   // R10 bit lasts sixteen ticks
   bit_len_a: assert property ($changed(tx_state_ff) && tx_state_ff != TX_IDLE // R10
      && $past(tx_state_ff) != TX_IDLE |-> $past(tx_tick_ff) == `SU_TICK_LAST)
      else $error("Bit length wrong");
   // R13 interrupt needs enable
   irq_mask_a: assert property (rx_irq |-> $past(rip_ff && rie_ff)) // R13
      else $error("Interrupt not gated");
   // R11 mode 0 drives data pin
   shift_drive_a: assert property (mode0 && tx_state_ff == TX_DATA // R11
      |=> serial_in_pin_oe)
      else $error("Mode 0 data not driven");

   async_rx_c:  cover property (!mode0 && rx_set);
   shift_rx_c:  cover property (mode0 && rx_state_ff == RX_SYNC ##[1:300] rip_ff);
   overrun_c:   cover property (rx_set && !fifo_ready);
   tx_done_c:   cover property (tx_set ##1 tip_ff);
endmodule : su_uart
`default_nettype wire

// ==== test/su_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
module su_peer (
   input  wire logic mclk,
   input  wire logic line_in,
   input  wire logic shift_dat,
   input  wire logic sync_mode,
   input  wire logic nine,
   input  var  int   bit_clks,
   output var  logic line_out
);
   logic [7:0] sh;
   logic [8:0] got_word;
   event       got_ev;
   initial begin
      line_out = 1'b1;
   end
   // ----------------------------------------
   // Receive side
   // ----------------------------------------
   // async frame taken at bit centres
   always begin
      @(negedge line_in iff !sync_mode);
      repeat (bit_clks / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_clks) @(posedge mclk);
         sh[i] = line_in;
      end
      // ninth bit and stop bit both count in 9-bit modes
      repeat (bit_clks) @(posedge mclk);
      got_word = {line_in, sh};
      if (nine) begin
         repeat (bit_clks) @(posedge mclk);
         got_word[8] = got_word[8] & line_in;
      end
      ->got_ev;
   end
   // shift clock rises mid-bit, LSB first
   always begin
      for (int i = 0; i < 8; i++) begin
         @(posedge line_in iff sync_mode);
         sh[i] = shift_dat;
      end
      got_word = {1'b1, sh};
      ->got_ev;
   end
   // ----------------------------------------
   // Transmit side, idle high
   // ----------------------------------------
   // start low, eight data, stop high
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out <= f[i];
         repeat (bit_clks) @(posedge mclk);
      end
   endtask : send
   // mode 0 data changes after each falling shift clock
   task automatic shift_send(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(negedge line_in);
         line_out <= b[i];
      end
      @(posedge line_in);
      line_out <= 1'b1;
   endtask : shift_send
endmodule : su_peer
`default_nettype wire

// ==== test/serial_port_uart_modes_0_1_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "su_regs.svh"
module serial_port_uart_modes_0_1_tb;
   logic       mclk;
   logic       reset_n;
   logic [7:0] reg_addr;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       rx_irq;
   logic       tx_irq;
   logic [1:0] uart_clk_sel;
   logic       serial_out_pin;
   logic       pin_o;
   logic       pin_oe;
   logic       peer_line;
   wire        pin_w = pin_oe ? pin_o : peer_line;
   logic       sync_m;
   logic       nine_m;
   logic       rd_pend;
   int         bclk;
   int         seed;
   int         fail_count;
   int         comparisons;
   logic [7:0] b [3];
   logic [15:0] rq [$];
   logic [8:0] wq [$];
   int         dv [3] = '{5, 2, 0};
   int         bc [3] = '{16, 48, 16};
   logic [7:0] hi [3] = '{8'h88, 8'hc0, 8'h00};

   su_uart i_su_uart (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .rx_irq(rx_irq), .tx_irq(tx_irq),
      .uart_clk_sel(uart_clk_sel), .serial_out_pin(serial_out_pin),
      .serial_in_pin_i(pin_w), .serial_in_pin_o(pin_o),
      .serial_in_pin_oe(pin_oe));
   su_peer i_su_peer (.mclk(mclk), .line_in(serial_out_pin), .shift_dat(pin_w),
      .sync_mode(sync_m), .nine(nine_m), .bit_clks(bclk), .line_out(peer_line));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // ----------------------------------------
   // Checking
   // ----------------------------------------
   task automatic chk_lvl(input string n, input logic [8:0] e, input logic [8:0] s);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk_lvl
   task automatic chk_rd();
      logic [15:0] x;
      x = rq.pop_front();
      chk_lvl("register read", 9'(x[7:0] & x[15:8]), 9'(reg_rdata & x[15:8]));
   endtask : chk_rd
   task automatic chk_word();
      logic [8:0] e;
      e = (wq.size() != 0) ? wq.pop_front() : 9'h000;
      chk_lvl("serial word", e, i_su_peer.got_word);
   endtask : chk_word
   always @(posedge mclk) rd_pend <= reg_rd;
   always @(negedge mclk) if (rd_pend) chk_rd();
   always @(i_su_peer.got_ev) chk_word();
   task automatic test_done();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done
   // ----------------------------------------
   // Register and serial drivers
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e,
                     input logic [7:0] m = 8'hff);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      rq.push_back({m, e});
      @(negedge mclk);
      reg_rd = 1'b0;
   endtask : rd
   task automatic wait_on(input int k);
      int n;
      n = 0;
      while (!((k == 1) ? tx_irq === 1'b1 : wq.size() == 0)) begin
         @(negedge mclk);
         n++;
         if (n > 3000) begin
            fail_count++;
            $display("[ERR] wait %0d expected 1 seen 0", k);
            test_done();
         end
      end
   endtask : wait_on
   // Second write lands while busy and must be dropped
   task automatic tx_one(input logic [7:0] d, input int left, input logic e9);
      wq.push_back({e9, d});
      wr(`SU_BUFFER_OFF, d);
      wr(`SU_BUFFER_OFF, ~d);
      wait_on(1);
      chk_lvl("words at flag", 9'(left), 9'(wq.size()));
      wait_on(2);
      repeat (12 * bclk) @(negedge mclk);
      wr(`SU_CTRL_LOW_OFF, 8'h02);
   endtask : tx_one
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 32'h07a2_e002;
      reset_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      sync_m = 1'b0;
      nine_m = 1'b0;
      bclk = 32;
      repeat (3) @(negedge mclk);
      reset_n = 1'b1;
      for (int i = 0; i < 5; i++) rd(8'(8'hf9 + i), 8'h00);
      wr(`SU_CTRL_LOW_OFF, 8'hfe);
      rd(`SU_CTRL_LOW_OFF, 8'h8e);
      chk_lvl("clock select", 9'h003, 9'(uart_clk_sel));
      wr(`SU_CTRL_LOW_OFF, 8'h02);
      b[0] = 8'($random(seed));
      wr(`SU_DIVISOR_OFF, b[0]);
      rd(`SU_DIVISOR_OFF, b[0]);
      wr(`SU_DIVISOR_OFF, 8'h01);
      wr(`SU_CTRL_HIGH_OFF, 8'h52);
      for (int i = 0; i < 3; i++) b[i] = 8'($random(seed));
      tx_one(b[0], 1, 1'b1);
      // Three frames without reads overrun the two-entry buffer
      for (int i = 0; i < 3; i++) i_su_peer.send(b[i]);
      chk_lvl("rx irq", 9'h001, 9'(rx_irq));
      rd(`SU_BUFFER_OFF, b[0]);
      rd(`SU_BUFFER_OFF, b[1]);
      rd(`SU_BUFFER_OFF, 8'h00);
      rd(`SU_CTRL_HIGH_OFF, 8'h53, 8'hfb);
      wr(`SU_CTRL_HIGH_OFF, 8'h52);
      rd(`SU_CTRL_HIGH_OFF, 8'h52, 8'hfb);
      wr(`SU_CTRL_HIGH_OFF, 8'h50);
      i_su_peer.send(b[2]);
      repeat (4) @(negedge mclk);
      chk_lvl("rx irq masked", 9'h000, 9'(rx_irq));
      rd(`SU_CTRL_HIGH_OFF, 8'h51, 8'hfb);
      rd(`SU_BUFFER_OFF, b[2]);
      for (int m = 0; m < 3; m++) begin
         bclk = bc[m];
         nine_m = (m < 2);
         sync_m = (m == 2);
         wr(`SU_DIVISOR_OFF, 8'(dv[m]));
         wr(`SU_CTRL_HIGH_OFF, hi[m]);
         tx_one(8'($random(seed)), (m == 2) ? 0 : 1, m != 1);
      end
      // Mode 0 receive: the peer shifts a byte in on the device's shift clock
      b[0] = 8'($random(seed));
      wq.push_back({1'b1, b[0]});
      fork
         i_su_peer.shift_send(b[0]);
      join_none
      wr(`SU_CTRL_HIGH_OFF, 8'h12);
      wait_on(2);
      repeat (2 * bclk) @(negedge mclk);
      chk_lvl("rx irq shift", 9'h001, 9'(rx_irq));
      rd(`SU_BUFFER_OFF, b[0]);
      rd(`SU_CTRL_HIGH_OFF, 8'h13, 8'hfb);
      repeat (2) @(negedge mclk);
      test_done();
   end
endmodule : serial_port_uart_modes_0_1_tb
`default_nettype wire
